// *** pkg/ssf_pkg.sv ***
// Functional notes
// - status resets and standby-loads to 84h
// - writing 1 to flags ignored; 0 clears after read
// - tx done and multiproc rx bits read-only; multiproc tx bit writable
// - tx empty sets on load into shifter
// - tx empty sets when tx enable cleared
// - dma data write clears tx empty
// - rx full sets on error-free received character
// - dma read of rx data clears rx full
// - errors keep rx full; rx disable keeps rx data/full
// - overrun when rx full; new char dropped
// - overrun halts receive; sync mode halts transmit
// - rx disable leaves overrun unchanged
// - async stop bit zero sets framing flag
// - only first stop bit checked
// - framing error loads data, rx full unset
// - framing halts receive; sync halts transmit
// - tx done sets at last bit if empty
// - async parity mismatch sets parity flag
// - tx done clears with tx empty clears
package ssf_pkg;

    // register port
    localparam int          ADDR_W      = 2;
    localparam int          DATA_W      = 8;
    localparam logic [1:0]  OFS_STATUS  = 2'h0;
    localparam logic [1:0]  OFS_RXDATA  = 2'h1;
    localparam logic [1:0]  OFS_TXDATA  = 2'h2;
    localparam logic [1:0]  OFS_CTRL    = 2'h3;

    // status register field positions
    localparam int BIT_TX_EMPTY  = 7;
    localparam int BIT_RX_FULL   = 6;
    localparam int BIT_OVERRUN   = 5;
    localparam int BIT_FRAMING   = 4;
    localparam int BIT_PARITY    = 3;
    localparam int BIT_TX_DONE   = 2;
    localparam int BIT_MP_RX     = 1;
    localparam int BIT_MP_TX     = 0;

    // control register field positions
    localparam int CTL_TX_EN     = 0;
    localparam int CTL_RX_EN     = 1;
    localparam int CTL_SYNC      = 2;
    localparam int CTL_PAR_EN    = 3;
    localparam int CTL_PAR_ODD   = 4;
    localparam int CTL_TWO_STOP  = 5;
    localparam int CTL_MP_FMT    = 6;

    // reset values
    localparam logic [7:0] STATUS_RST = 8'h84;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] RXDATA_RST = 8'h00;
    localparam logic [7:0] TXDATA_RST = 8'hff;

    // outcome of one finished reception
    typedef enum logic [1:0] {
        RX_OUT_NONE    = 2'b00,
        RX_OUT_GOOD    = 2'b01,
        RX_OUT_ERROR   = 2'b10,
        RX_OUT_OVERRUN = 2'b11
    } ssf_rx_out_t;

    // receiver finishing one character
    typedef struct packed {
        logic       done;
        logic [7:0] data;
        logic       par_bit;
        logic       stop_bit;
        logic       mp_bit;
    } ssf_rx_evt_t;

    // dma controller accesses to the data registers
    typedef struct packed {
        logic       tdr_wr;
        logic       rdr_rd;
        logic [7:0] wdata;
    } ssf_dma_t;

endpackage

// *** logic/ssf_flag.sv ***
`timescale 1ns/100ps
// one status flag with read-then-write-0 clear
module ssf_flag #(
    parameter logic INIT_VAL = 1'b0
) (
    // clock and initialisation
    input  wire logic clk,
    input  wire logic init,
    // software access to the status register
    input  wire logic rd_hit,
    input  wire logic wr_hit,
    input  wire logic wr_bit,
    // hardware events
    input  wire logic hw_set,
    input  wire logic hw_clr,
    // state
    output logic      flag_q,
    output logic      sw_clr
);

    logic armed_q;   // flag was read while set
    logic armed_d;   // next marker
    logic flag_d;    // next flag
    logic wr_clr;    // armed write of 0

    // write of 0 only counts after a read that saw 1
    assign wr_clr = wr_hit & ~wr_bit & armed_q;
    // clear that really took effect
    assign sw_clr = wr_clr & ~hw_set;

    // marker: armed by read while set, dropped on clear
    always_comb begin
        if (rd_hit && flag_q) begin
            armed_d = 1'b1;
        end else if (wr_clr || !flag_q) begin
            armed_d = 1'b0;
        end else begin
            armed_d = armed_q;
        end
    end

    // flag: set wins over any clear
    always_comb begin
        if (hw_set) begin
            flag_d = 1'b1;
        end else if (wr_clr || hw_clr) begin
            flag_d = 1'b0;
        end else begin
            flag_d = flag_q;
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (init) begin
            flag_q  <= INIT_VAL;
            armed_q <= 1'b0;
        end else begin
            flag_q  <= flag_d;
            armed_q <= armed_d;
        end
    end

endmodule

// *** logic/ssf_status.sv ***
`timescale 1ns/100ps
// status flags of a serial channel with its data registers
module ssf_status
    import ssf_pkg::*;
#(
    parameter int DW = DATA_W
) (
    // clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              RESET,
    input  wire logic              STANDBY,
    // register port
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [7:0]        WDATA,
    input  wire logic              WR_STB,
    input  wire logic              RD_STB,
    output logic      [7:0]        RDATA,
    // receiver events
    input  wire ssf_rx_evt_t       RX_EVT,
    // transmitter events
    input  wire logic              TX_LOAD,
    input  wire logic              TX_LAST_BIT,
    // dma controller
    input  wire ssf_dma_t          DMA,
    // toward the shifters
    output logic      [7:0]        TX_DATA,
    output logic                   MP_BIT_TX,
    output logic                   TX_ENABLE,
    output logic                   RX_ENABLE,
    output logic                   SYNC_MODE,
    output logic                   TWO_STOP,
    output logic                   RX_HALT,
    output logic                   TX_HALT,
    // status view
    output logic      [7:0]        STATUS
);

    ////////////////////////////////////////////////////////////////
    // elaboration check
    ////////////////////////////////////////////////////////////////

    // the flag layout is fixed to one byte
    if (DW != 8) begin : g_bad_width
        $error("ssf_status serves only an 8-bit data width");
    end

    ////////////////////////////////////////////////////////////////
    // declarations
    ////////////////////////////////////////////////////////////////

    logic        init;          // reset or standby entry
    logic        rd_status;     // read strobe on status
    logic        wr_status;     // write strobe on status
    logic        wr_txdata;     // cpu write of tx data
    logic        wr_ctrl;       // write to control

    logic [7:0]  ctrl_q;        // control register
    logic [7:0]  ctrl_d;        // its next value
    logic [7:0]  rx_data_q;     // receive data register
    logic [7:0]  rx_data_d;     // its next value
    logic [7:0]  tx_data_q;     // transmit data register
    logic [7:0]  tx_data_d;     // its next value
    logic        mp_rx_q;       // received multiprocessor bit
    logic        mp_rx_d;       // its next value
    logic        mp_tx_q;       // multiprocessor bit to send
    logic        mp_tx_d;       // its next value
    logic        tx_done_q;     // transmit end flag
    logic        tx_done_d;     // its next value
    logic [7:0]  rdata_q;       // read data register
    logic [7:0]  rdata_d;       // its next value
    logic [7:0]  rd_mux;        // selected read word

    logic        tx_en;         // control: transmit enable
    logic        rx_en;         // control: receive enable
    logic        sync_md;       // control: synchronous mode
    logic        par_en;        // control: parity used
    logic        par_odd;       // control: odd parity
    logic        mp_fmt;        // control: multiprocessor format
    logic        tx_en_fall;    // transmit enable written 1 to 0

    logic        tx_empty;      // transmit empty flag
    logic        rx_full;       // receive full flag
    logic        overrun;       // overrun flag
    logic        framing;       // framing error flag
    logic        parity;        // parity error flag
    logic        tx_empty_swclr; // software cleared tx empty

    logic        rx_take;       // reception finished and accepted
    logic        fer_hit;       // stop bit sampled low
    logic        per_hit;       // parity mismatch
    logic        err_hit;       // framing or parity error
    ssf_rx_out_t rx_out;        // classified outcome
    logic        rx_load;       // move character into rx data
    logic        set_rx_full;   // set event for rx full
    logic        set_overrun;   // set event for overrun
    logic        set_tx_empty;  // set event for tx empty
    logic        set_tx_done;   // set event for tx end

    ////////////////////////////////////////////////////////////////
    // address decode
    ////////////////////////////////////////////////////////////////

    // reset and standby both load the documented initial values
    assign init      = RESET | STANDBY;
    assign rd_status = RD_STB & (ADDR == OFS_STATUS);
    assign wr_status = WR_STB & (ADDR == OFS_STATUS);
    // no write decode for rx data: that register is read-only
    assign wr_txdata = WR_STB & (ADDR == OFS_TXDATA);
    assign wr_ctrl   = WR_STB & (ADDR == OFS_CTRL);

    ////////////////////////////////////////////////////////////////
    // control fields
    ////////////////////////////////////////////////////////////////

    // field picks from the control register
    assign tx_en   = ctrl_q[CTL_TX_EN];
    assign rx_en   = ctrl_q[CTL_RX_EN];
    assign sync_md = ctrl_q[CTL_SYNC];
    assign par_en  = ctrl_q[CTL_PAR_EN];
    assign par_odd = ctrl_q[CTL_PAR_ODD];
    assign mp_fmt  = ctrl_q[CTL_MP_FMT];

    // a write that turns the transmitter off
    assign tx_en_fall = wr_ctrl & tx_en & ~WDATA[CTL_TX_EN];

    // control register next value
    assign ctrl_d = wr_ctrl ? WDATA : ctrl_q;

    ////////////////////////////////////////////////////////////////
    // halt of the shifters
    ////////////////////////////////////////////////////////////////

    // any error flag stops reception until cleared
    assign RX_HALT = overrun | framing | parity;
    // in synchronous mode the transmitter stops as well
    assign TX_HALT = sync_md & RX_HALT;

    ////////////////////////////////////////////////////////////////
    // receive classification
    ////////////////////////////////////////////////////////////////

    // a disabled or halted receiver changes nothing
    assign rx_take = RX_EVT.done & rx_en & ~RX_HALT;

    // framing: async only, first stop bit only
    assign fer_hit = ~sync_md & ~RX_EVT.stop_bit;

    // parity: ones count with parity bit against the setting
    assign per_hit = ~sync_md & par_en &
                     ((^{RX_EVT.data, RX_EVT.par_bit}) ^ par_odd);

    assign err_hit = fer_hit | per_hit;

    // outcome of the finished character
    always_comb begin
        if (!rx_take) begin
            rx_out = RX_OUT_NONE;
        end else if (rx_full) begin
            rx_out = RX_OUT_OVERRUN;
        end else if (err_hit) begin
            rx_out = RX_OUT_ERROR;
        end else begin
            rx_out = RX_OUT_GOOD;
        end
    end

    // act on the outcome
    always_comb begin
        case (rx_out)
            RX_OUT_GOOD: begin
                rx_load     = 1'b1;
                set_rx_full = 1'b1;
                set_overrun = 1'b0;
            end
            RX_OUT_ERROR: begin
                // character stored, full flag left alone
                rx_load     = 1'b1;
                set_rx_full = 1'b0;
                set_overrun = 1'b0;
            end
            RX_OUT_OVERRUN: begin
                // older character kept, new one dropped
                rx_load     = 1'b0;
                set_rx_full = 1'b0;
                set_overrun = 1'b1;
            end
            default: begin
                rx_load     = 1'b0;
                set_rx_full = 1'b0;
                set_overrun = 1'b0;
            end
        endcase
    end

    // receive data register next value
    assign rx_data_d = rx_load ? RX_EVT.data : rx_data_q;

    // multiprocessor bit follows each stored async character in multiprocessor format
    assign mp_rx_d = (rx_load && mp_fmt && !sync_md) ?
                     RX_EVT.mp_bit : mp_rx_q;

    ////////////////////////////////////////////////////////////////
    // transmit side
    ////////////////////////////////////////////////////////////////

    // data moved to the shifter, or transmitter switched off
    assign set_tx_empty = TX_LOAD | tx_en_fall;

    // last bit out with nothing new waiting
    assign set_tx_done = (TX_LAST_BIT & tx_empty) | tx_en_fall;

    // transmit data register: dma write wins over cpu write
    assign tx_data_d = DMA.tdr_wr ? DMA.wdata :
                       wr_txdata  ? WDATA     : tx_data_q;

    // transmit end flag, set beats clear
    assign tx_done_d = set_tx_done ? 1'b1 :
                       (tx_empty_swclr | DMA.tdr_wr) ? 1'b0 :
                       tx_done_q;

    // only the multiprocessor transmit bit is plainly writable
    assign mp_tx_d = wr_status ? WDATA[BIT_MP_TX] : mp_tx_q;

    ////////////////////////////////////////////////////////////////
    // clearable flags
    ////////////////////////////////////////////////////////////////

    // transmit empty, starts set
    ssf_flag #(
        .INIT_VAL (1'b1)
    ) u_tx_empty (
        .clk      (REF_CLK),
        .init     (init),
        .rd_hit   (rd_status),
        .wr_hit   (wr_status),
        .wr_bit   (WDATA[BIT_TX_EMPTY]),
        .hw_set   (set_tx_empty),
        .hw_clr   (DMA.tdr_wr),
        .flag_q   (tx_empty),
        .sw_clr   (tx_empty_swclr)
    );

    // receive full
    ssf_flag u_rx_full (
        .clk      (REF_CLK),
        .init     (init),
        .rd_hit   (rd_status),
        .wr_hit   (wr_status),
        .wr_bit   (WDATA[BIT_RX_FULL]),
        .hw_set   (set_rx_full),
        .hw_clr   (DMA.rdr_rd),
        .flag_q   (rx_full),
        .sw_clr   ()
    );

    // overrun
    ssf_flag u_overrun (
        .clk      (REF_CLK),
        .init     (init),
        .rd_hit   (rd_status),
        .wr_hit   (wr_status),
        .wr_bit   (WDATA[BIT_OVERRUN]),
        .hw_set   (set_overrun),
        .hw_clr   (1'b0),
        .flag_q   (overrun),
        .sw_clr   ()
    );

    // framing error
    ssf_flag u_framing (
        .clk      (REF_CLK),
        .init     (init),
        .rd_hit   (rd_status),
        .wr_hit   (wr_status),
        .wr_bit   (WDATA[BIT_FRAMING]),
        .hw_set   (rx_out == RX_OUT_ERROR && fer_hit),
        .hw_clr   (1'b0),
        .flag_q   (framing),
        .sw_clr   ()
    );

    // parity error
    ssf_flag u_parity (
        .clk      (REF_CLK),
        .init     (init),
        .rd_hit   (rd_status),
        .wr_hit   (wr_status),
        .wr_bit   (WDATA[BIT_PARITY]),
        .hw_set   (rx_out == RX_OUT_ERROR && per_hit),
        .hw_clr   (1'b0),
        .flag_q   (parity),
        .sw_clr   ()
    );

    ////////////////////////////////////////////////////////////////
    // read path
    ////////////////////////////////////////////////////////////////

    // assembled status byte
    assign STATUS = {tx_empty, rx_full, overrun, framing,
                     parity, tx_done_q, mp_rx_q, mp_tx_q};

    // read selection
    always_comb begin
        case (ADDR)
            OFS_STATUS: rd_mux = STATUS;
            OFS_RXDATA: rd_mux = rx_data_q;
            OFS_TXDATA: rd_mux = tx_data_q;
            OFS_CTRL:   rd_mux = ctrl_q;
            default:    rd_mux = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    assign rdata_d = RD_STB ? rd_mux : 8'h00;

    ////////////////////////////////////////////////////////////////
    // registers
    ////////////////////////////////////////////////////////////////

    // control and data registers, loaded with their reset values by reset and standby
    always_ff @(posedge REF_CLK) begin
        if (init) begin
            ctrl_q    <= CTRL_RST;
            rx_data_q <= RXDATA_RST;
            tx_data_q <= TXDATA_RST;
        end else begin
            ctrl_q    <= ctrl_d;
            rx_data_q <= rx_data_d;
            tx_data_q <= tx_data_d;
        end
    end

    // status bits held outside the flag cells
    always_ff @(posedge REF_CLK) begin
        if (init) begin
            tx_done_q <= STATUS_RST[BIT_TX_DONE];
            mp_rx_q   <= STATUS_RST[BIT_MP_RX];
            mp_tx_q   <= STATUS_RST[BIT_MP_TX];
        end else begin
            tx_done_q <= tx_done_d;
            mp_rx_q   <= mp_rx_d;
            mp_tx_q   <= mp_tx_d;
        end
    end

    // read data register
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    ////////////////////////////////////////////////////////////////

    // register-driven outputs toward the shifters and software
    assign RDATA     = rdata_q;
    assign TX_DATA   = tx_data_q;
    assign MP_BIT_TX = mp_tx_q;
    assign TX_ENABLE = tx_en;
    assign RX_ENABLE = rx_en;
    assign SYNC_MODE = sync_md;
    assign TWO_STOP  = ctrl_q[CTL_TWO_STOP];

endmodule

// *** tb/ssf_dma_model.sv ***
`timescale 1ns/100ps
// dma side: turns bench requests into one-cycle data-register accesses
module ssf_dma_model
    import ssf_pkg::*;
(
    // clock and requests
    input  wire logic       clk,
    input  wire logic       go_wr,
    input  wire logic       go_rd,
    input  wire logic [7:0] data,
    // access toward the block
    output ssf_dma_t        dma
);
    // start idle so no unknown reaches the block
    initial dma = '0;
    ////////////////////////////////////////////////////////////////////
    // one access per request; write data only means something with it
    always @(posedge clk) begin
        dma.tdr_wr <= go_wr;
        dma.rdr_rd <= go_rd;
        dma.wdata  <= go_wr ? data : ~dma.wdata;
    end
endmodule

// *** tb/ssf_status_assertions.sv ***
`timescale 1ns/100ps
// watches the ports of the status flag block
module ssf_status_assertions
    import ssf_pkg::*;
(
    // clock and reset
    input wire logic              REF_CLK,
    input wire logic              RESET,
    input wire logic              STANDBY,
    // register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [7:0]        WDATA,
    input wire logic              WR_STB,
    input wire logic              RD_STB,
    // events
    input wire ssf_rx_evt_t       RX_EVT,
    input wire logic              TX_LOAD,
    input wire logic              TX_LAST_BIT,
    input wire ssf_dma_t          DMA,
    // outputs
    input wire logic              TX_ENABLE,
    input wire logic              RX_ENABLE,
    input wire logic              SYNC_MODE,
    input wire logic              RX_HALT,
    input wire logic              TX_HALT,
    input wire logic [7:0]        STATUS
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    // status write with nothing else happening in that cycle
    wire st_wr = WR_STB && ADDR == OFS_STATUS;
    wire quiet = !STANDBY && !RX_EVT.done && !TX_LOAD && !TX_LAST_BIT
                 && !DMA.tdr_wr && !DMA.rdr_rd;
    ////////////////////////////////////////////////////////////////////
    standby_init_a: assert property (STANDBY |=> STATUS == STATUS_RST)
        else $error("status not initialised by standby");
    tx_load_a: assert property (TX_LOAD |=> STATUS[7])
        else $error("tx empty not set by load");
    tx_off_a: assert property (WR_STB && ADDR == OFS_CTRL && TX_ENABLE
        && !WDATA[CTL_TX_EN] |=> STATUS[7] && STATUS[2])
        else $error("tx disable did not set tx flags");
    dma_wr_a: assert property (DMA.tdr_wr && !TX_LOAD && !TX_LAST_BIT
        && !WR_STB && !STANDBY |=> !STATUS[7] && !STATUS[2])
        else $error("dma write did not clear tx flags");
    overrun_a: assert property (RX_EVT.done && RX_ENABLE && !RX_HALT
        && STATUS[6] && !STANDBY |=> STATUS[5])
        else $error("overrun not flagged");
    halt_hold_a: assert property (RX_EVT.done && (RX_HALT || !RX_ENABLE)
        && !WR_STB && !DMA.rdr_rd && !STANDBY |=> $stable(STATUS[6:3]))
        else $error("receive flags moved while halted");
    read_only_a: assert property (st_wr && quiet
        |=> $stable(STATUS[1]) && !$rose(STATUS[2]))
        else $error("read-only status bit written");
    no_set_a: assert property (st_wr && quiet
        |=> (STATUS & ~$past(STATUS) & 8'hf8) == 8'h00)
        else $error("status flag set by write");
    clear_armed_a: assert property (RD_STB && ADDR == OFS_STATUS
        && STATUS[5] ##[1:2] st_wr && !WDATA[5] && !RX_EVT.done
        && !STANDBY |=> !STATUS[5])
        else $error("armed overrun not cleared");
    halt_out_a: assert property (RX_HALT == |STATUS[5:3]
        && TX_HALT == (SYNC_MODE && RX_HALT))
        else $error("halt outputs wrong");
    tx_end_a: assert property (TX_LAST_BIT && STATUS[7] && !DMA.tdr_wr
        && !WR_STB |=> STATUS[2])
        else $error("tx done not set");
endmodule
////////////////////////////////////////////////////////////////////////
bind ssf_status ssf_status_assertions u_chk (.REF_CLK(REF_CLK),
    .RESET(RESET), .STANDBY(STANDBY), .ADDR(ADDR), .WDATA(WDATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RX_EVT(RX_EVT), .TX_LOAD(TX_LOAD),
    .TX_LAST_BIT(TX_LAST_BIT), .DMA(DMA), .TX_ENABLE(TX_ENABLE),
    .RX_ENABLE(RX_ENABLE), .SYNC_MODE(SYNC_MODE), .RX_HALT(RX_HALT),
    .TX_HALT(TX_HALT), .STATUS(STATUS));

// *** tb/ssf_status_tb.sv ***
`timescale 1ns/100ps
// bench for the status flag block
module ssf_status_tb
    import ssf_pkg::*;
;
    logic        clk, rst, stby, wr, rd, txl, txb, gw, gr, txh, mpt, tws;
    logic        rsee = 1'b0;
    logic [1:0]  adr;
    logic [7:0]  wd, rdat, txd, gd;
    logic [7:0]  dv [8];
    logic [7:0]  expq [$];
    ssf_rx_evt_t rxe;
    ssf_dma_t    dma;
    int          num_errors, checks, seed;
    ////////////////////////////////////////////////////////////////////
    ssf_status dut (.REF_CLK(clk), .RESET(rst), .STANDBY(stby),
        .ADDR(adr), .WDATA(wd), .WR_STB(wr), .RD_STB(rd), .RDATA(rdat),
        .RX_EVT(rxe), .TX_LOAD(txl), .TX_LAST_BIT(txb), .DMA(dma),
        .TX_DATA(txd), .MP_BIT_TX(mpt), .TX_ENABLE(), .RX_ENABLE(),
        .SYNC_MODE(), .TWO_STOP(tws), .RX_HALT(), .TX_HALT(txh),
        .STATUS());
    ssf_dma_model u_dma (.clk(clk), .go_wr(gw), .go_rd(gr), .data(gd),
        .dma(dma));
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] s, e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic summarize;
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one bus cycle; l raises a tx load in the same cycle
    task automatic bus(input logic w, input logic [1:0] a,
                       input logic [7:0] d, input logic l);
        @(posedge clk);
        {adr, wd} <= {a, d};
        {wr, rd, txl} <= {w, !w, l};
        @(posedge clk);
        {wr, rd, txl} <= 3'b000;
    endtask
    // read with its expected answer noted first
    task automatic rdx(input logic [1:0] a, input logic [7:0] e);
        expq.push_back(e);
        bus(1'b0, a, 8'h00, 1'b0);
    endtask
    // pulses of load, last bit, dma write, dma read
    task automatic ev(input logic [3:0] k, input logic [7:0] v);
        @(posedge clk);
        {txl, txb, gw, gr, gd} <= {k, v};
        @(posedge clk);
        {txl, txb, gw, gr} <= 4'h0;
    endtask
    task automatic rx(input logic [7:0] d, input logic p, s);
        @(posedge clk);
        rxe <= '{1'b1, d, p, s, 1'b0};
        @(posedge clk);
        rxe.done <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    // read data stands one cycle after the strobe
    always @(posedge clk) begin
        if (rsee)
            chk("rdata", rdat, expq.pop_front());
        rsee <= rd;
    end
    // hang guard
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        {rst, stby, wr, rd, txl, txb, gw, gr} = 8'h80;
        {adr, wd, gd} = '0;
        rxe = '0;
        seed = 88375;
        foreach (dv[i]) dv[i] = $random(seed);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdx(OFS_STATUS, 8'h84);
        bus(1'b1, OFS_STATUS, 8'hff, 1'b0);
        rdx(OFS_STATUS, 8'h85);
        chk("mp bit tx", {7'h00, mpt}, 8'h01);
        bus(1'b1, OFS_STATUS, 8'h00, 1'b0);
        rdx(OFS_STATUS, 8'h00);
        bus(1'b1, OFS_CTRL, 8'h03, 1'b0);
        ev(4'h2, dv[0]);
        rdx(OFS_STATUS, 8'h00);
        chk("tx data", txd, dv[0]);
        ev(4'h8, 8'h00);
        rdx(OFS_STATUS, 8'h80);
        ev(4'h4, 8'h00);
        rdx(OFS_STATUS, 8'h84);
        ev(4'h2, dv[1]);
        rdx(OFS_STATUS, 8'h00);
        ev(4'h8, 8'h00);
        rdx(OFS_STATUS, 8'h80);
        bus(1'b1, OFS_STATUS, 8'h00, 1'b1);
        rdx(OFS_STATUS, 8'h80);
        bus(1'b1, OFS_CTRL, 8'h02, 1'b0);
        rdx(OFS_STATUS, 8'h84);
        rx(dv[2], ^dv[2], 1'b1);
        rdx(OFS_STATUS, 8'hc4);
        rdx(OFS_RXDATA, dv[2]);
        rx(dv[3], ^dv[3], 1'b1);
        rdx(OFS_STATUS, 8'he4);
        rdx(OFS_RXDATA, dv[2]);
        ev(4'h1, 8'h00);
        rdx(OFS_STATUS, 8'ha4);
        rx(dv[4], ^dv[4], 1'b1);
        rdx(OFS_STATUS, 8'ha4);
        rdx(OFS_RXDATA, dv[2]);
        bus(1'b1, OFS_CTRL, 8'h00, 1'b0);
        rdx(OFS_STATUS, 8'ha4);
        bus(1'b1, OFS_STATUS, 8'hde, 1'b0);
        rdx(OFS_STATUS, 8'h84);
        bus(1'b1, OFS_CTRL, 8'h22, 1'b0);
        rx(dv[5], ^dv[5], 1'b0);
        rdx(OFS_STATUS, 8'h94);
        rdx(OFS_RXDATA, dv[5]);
        chk("two stop", {7'h00, tws}, 8'h01);
        bus(1'b1, OFS_CTRL, 8'h26, 1'b0);
        rx(dv[6], ^dv[6], 1'b1);
        rdx(OFS_RXDATA, dv[5]);
        chk("tx halt", {7'h00, txh}, 8'h01);
        rdx(OFS_STATUS, 8'h94);
        bus(1'b1, OFS_STATUS, 8'h00, 1'b0);
        rdx(OFS_STATUS, 8'h00);
        bus(1'b1, OFS_CTRL, 8'h0a, 1'b0);
        rx(dv[7], ~^dv[7], 1'b1);
        rdx(OFS_STATUS, 8'h08);
        rdx(OFS_RXDATA, dv[7]);
        @(posedge clk);
        stby <= 1'b1;
        @(posedge clk);
        stby <= 1'b0;
        rdx(OFS_STATUS, 8'h84);
        repeat (3) @(posedge clk);
        summarize();
    end
endmodule
